// File: design/adcm_top.sv
// Channel select, restart, settling and serial readout around the filter.
// Assumes pins asynchronous to clk_sys_i and a modulator bit per divided tick.
// What this block does
// - Select pins map high/low 00,01,10,11 to inputs one to four.
// - Select pins sampled on clock falling edge; any change restarts conversion.
// - First ready after a change carries data of the new channel.
// - Ready raised only after five conversions following a restart.
// - New result in output register drives data/ready pin low.
// - A settled 24-bit filter result is written into the output register only when no word is pending or being read.
// - Modulator rate is clock over six; one word per 64 modulator cycles.
// - Word shifts out on the reader-supplied serial clock.
`timescale 1ns/1ns
`default_nettype none
`include "adcm_map.svh"
module adcm_top #(
    parameter int MOD_DIV = `ADCM_MOD_DIV,
    parameter int OSR = `ADCM_OSR,
    parameter int SETTLE = `ADCM_SETTLE
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // Channel select pins
    input wire logic input_select_high_i,
    input wire logic input_select_low_i,
    // Modulator side
    input wire logic mod_bit_i,
    output logic mod_clk_o,
    output adcm_pkg::adcm_chan_t mux_sel_o,
    // Serial readout
    input wire logic sclk_i,
    output logic result_out_and_ready_pin_o,
    output logic result_ready_flag_o
);
    localparam int WORD_W = `ADCM_WORD_W;
    localparam int DIV_W = $clog2(MOD_DIV);
    localparam int SET_W = $clog2(SETTLE + 1);
    localparam int BIT_W = $clog2(WORD_W + 1);
    generate
        if (MOD_DIV < 2 || SETTLE < 1) begin : g_bad
            $error("adcm_top: unsupported parameters");
        end
    endgenerate
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end
    // Pin synchronisers; first stages feed only second stages
    adcm_pkg::adcm_sel_t sel_s1, sel_s2, sel_neg;
    logic bit_s1, bit_s2, sclk_s1, sclk_s2, sclk_s3;
    logic sclk_rise, sclk_fall;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_s1 <= '0;
            sel_s2 <= '0;
            bit_s1 <= 1'b0;
            bit_s2 <= 1'b0;
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
        end else begin
            sel_s1 <= '{high: input_select_high_i, low: input_select_low_i};
            sel_s2 <= sel_s1;
            bit_s1 <= mod_bit_i;
            bit_s2 <= bit_s1;
            sclk_s1 <= sclk_i;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
        end
    end
    assign sclk_rise = sclk_s2 && !sclk_s3;
    assign sclk_fall = !sclk_s2 && sclk_s3;
    always_ff @(negedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_neg <= '0;
        end else begin
            sel_neg <= sel_s2;
        end
    end
    // Change detection and restart
    logic restart;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            mux_sel_o <= adcm_pkg::INPUT_ONE;
            restart <= 1'b0;
        end else begin
            restart <= (sel_neg != mux_sel_o);
            mux_sel_o <= adcm_pkg::adcm_chan_t'(sel_neg);
        end
    end
    // Modulator clock divider
    logic [DIV_W-1:0] div_cnt;
    logic mod_tick;
    assign mod_tick = (div_cnt == DIV_W'(MOD_DIV - 1));
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            mod_clk_o <= 1'b0;
        end else begin
            div_cnt <= mod_tick ? '0 : div_cnt + 1'b1;
            mod_clk_o <= (div_cnt < DIV_W'(MOD_DIV / 2));
        end
    end
    logic f_valid;
    logic [WORD_W-1:0] f_word;
    adcm_sinc5 #(
        .OSR(OSR),
        .ORDER(`ADCM_ORDER),
        .WORD_W(WORD_W)
    ) u_filter (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n),
        .clear_i(restart),
        .in_valid_i(mod_tick),
        .in_bit_i(bit_s2),
        .out_valid_o(f_valid),
        .out_word_o(f_word)
    );
    // Settling count: words before the fifth are withheld
    logic [SET_W-1:0] settle_cnt;
    logic settled;
    assign settled = (settle_cnt == SET_W'(SETTLE - 1));
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= '0;
        end else if (restart) begin
            settle_cnt <= '0;
        end else if (f_valid && !settled) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end
    // Readout; a word arriving mid-read is dropped
    adcm_pkg::adcm_state_t state;
    logic [WORD_W-1:0] shreg;
    logic [BIT_W-1:0] bit_cnt;
    logic load;
    assign load = f_valid && settled && !restart && state == adcm_pkg::ST_IDLE;
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= adcm_pkg::ST_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            result_out_and_ready_pin_o <= 1'b1;
            result_ready_flag_o <= 1'b0;
        end else if (restart) begin
            // Reader is expected not to switch mid-read, so abort is safe
            state <= adcm_pkg::ST_IDLE;
            result_out_and_ready_pin_o <= 1'b1;
            result_ready_flag_o <= 1'b0;
        end else begin
            unique case (state)
                adcm_pkg::ST_IDLE: begin
                    if (load) begin
                        shreg <= f_word;
                        bit_cnt <= '0;
                        result_out_and_ready_pin_o <= 1'b0;
                        result_ready_flag_o <= 1'b1;
                        state <= adcm_pkg::ST_READY;
                    end
                end
                adcm_pkg::ST_READY, adcm_pkg::ST_SHIFT: begin
                    if (sclk_rise && bit_cnt != BIT_W'(WORD_W)) begin
                        result_out_and_ready_pin_o <= shreg[WORD_W-1];
                        shreg <= {shreg[WORD_W-2:0], 1'b0};
                        bit_cnt <= bit_cnt + 1'b1;
                        result_ready_flag_o <= 1'b0;
                        state <= adcm_pkg::ST_SHIFT;
                    end else if (sclk_fall && bit_cnt == BIT_W'(WORD_W)) begin
                        result_out_and_ready_pin_o <= 1'b1;
                        state <= adcm_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end
    a_chan_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        1'b1 |=> mux_sel_o == $past(sel_neg))
        else $error("channel select mismatch");
    a_change_restart: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (sel_neg != mux_sel_o) |=> restart)
        else $error("channel change without restart");
    a_restart_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        restart |=> (state == adcm_pkg::ST_IDLE && settle_cnt == '0 && !result_ready_flag_o))
        else $error("stale ready after restart");
    a_settle_five: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        load |-> settle_cnt == SET_W'(SETTLE - 1))
        else $error("ready before settling");
    a_ready_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        load |=> (!result_out_and_ready_pin_o && result_ready_flag_o)[*2])
        else $error("pin not low on new data");
    a_word_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        load |=> shreg == $past(f_word))
        else $error("result not latched");
    a_mod_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        mod_tick |=> !mod_tick [*5] ##1 mod_tick)
        else $error("modulator rate wrong");
    a_shift_msb: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (sclk_rise && !restart && state != adcm_pkg::ST_IDLE && bit_cnt != BIT_W'(WORD_W))
        |=> result_out_and_ready_pin_o == $past(shreg[WORD_W-1]))
        else $error("serial bit wrong");
    c_restart: cover property (@(posedge clk_sys_i) disable iff (!rst_n) restart);
    c_load: cover property (@(posedge clk_sys_i) disable iff (!rst_n) load);
    c_read_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
        state == adcm_pkg::ST_SHIFT ##1 state == adcm_pkg::ST_IDLE);
endmodule
`default_nettype wire

// File: pkg/adcm_map.svh
// Named constants of the converter control block.
// Assumes inclusion by bare name from package and design files.
`ifndef ADCM_MAP_SVH
`define ADCM_MAP_SVH
`define ADCM_MOD_DIV 6
`define ADCM_OSR 64
`define ADCM_ORDER 5
`define ADCM_SETTLE 5
`define ADCM_WORD_W 24
`define ADCM_CH_ONE 2'h0
`define ADCM_CH_TWO 2'h1
`define ADCM_CH_THREE 2'h2
`define ADCM_CH_FOUR 2'h3
`define ADCM_ST_IDLE 2'h0
`define ADCM_ST_READY 2'h1
`define ADCM_ST_SHIFT 2'h3
`endif

// File: pkg/adcm_pkg.sv
// Types of the converter control block.
// Assumes adcm_map.svh on the include path.
`include "adcm_map.svh"
package adcm_pkg;
    typedef struct packed {
        logic high;
        logic low;
    } adcm_sel_t;
    typedef enum logic [1:0] {
        INPUT_ONE = `ADCM_CH_ONE,
        INPUT_TWO = `ADCM_CH_TWO,
        INPUT_THREE = `ADCM_CH_THREE,
        INPUT_FOUR = `ADCM_CH_FOUR
    } adcm_chan_t;
    typedef enum logic [1:0] {
        ST_IDLE = `ADCM_ST_IDLE,
        ST_READY = `ADCM_ST_READY,
        ST_SHIFT = `ADCM_ST_SHIFT
    } adcm_state_t;
endpackage

// File: design/adcm_sinc5.sv
// Cascaded integrator-comb averaging filter with decimation.
// Assumes one input bit per in_valid pulse, all on one clock.
`timescale 1ns/1ns
`default_nettype none
`include "adcm_map.svh"
module adcm_sinc5 #(
    parameter int OSR = `ADCM_OSR,
    parameter int ORDER = `ADCM_ORDER,
    parameter int WORD_W = `ADCM_WORD_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic clear_i,
    // Bitstream in
    input wire logic in_valid_i,
    input wire logic in_bit_i,
    // Word out
    output logic out_valid_o,
    output logic [WORD_W-1:0] out_word_o
);
    localparam int LOG_OSR = $clog2(OSR);
    localparam int ACC_W = ORDER * LOG_OSR + 1;
    generate
        if ((1 << LOG_OSR) != OSR || ORDER < 1 || WORD_W > ACC_W - 1) begin : g_bad
            $error("adcm_sinc5: unsupported parameters");
        end
    endgenerate
    logic [ACC_W-1:0] integ [1:ORDER];
    logic [ACC_W-1:0] dly [0:ORDER-1];
    logic [ACC_W-1:0] comb [0:ORDER];
    logic [LOG_OSR-1:0] dec_cnt;
    logic dec_tick;
    logic [WORD_W-1:0] next_word;
    assign dec_tick = in_valid_i && (dec_cnt == LOG_OSR'(OSR - 1));
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dec_cnt <= '0;
        end else if (clear_i) begin
            dec_cnt <= '0;
        end else if (in_valid_i) begin
            dec_cnt <= dec_cnt + 1'b1;
        end
    end
    genvar k;
    generate
        for (k = 1; k <= ORDER; k++) begin : g_stage
            logic [ACC_W-1:0] stage_in;
            if (k == 1) begin : g_first
                assign stage_in = {{(ACC_W-1){1'b0}}, in_bit_i};
            end else begin : g_next
                assign stage_in = integ[k-1];
            end
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    integ[k] <= '0;
                    dly[k-1] <= '0;
                end else if (clear_i) begin
                    integ[k] <= '0;
                    dly[k-1] <= '0;
                end else begin
                    if (in_valid_i) begin
                        integ[k] <= integ[k] + stage_in;
                    end
                    if (dec_tick) begin
                        dly[k-1] <= comb[k-1];
                    end
                end
            end
        end
    endgenerate
    always_comb begin
        comb[0] = integ[ORDER];
        for (int i = 1; i <= ORDER; i++) begin
            comb[i] = comb[i-1] - dly[i-1];
        end
        // Full scale lands one past the word range, so it saturates
        if (comb[ORDER][ACC_W-1]) begin
            next_word = '1;
        end else begin
            next_word = comb[ORDER][ACC_W-2 -: WORD_W];
        end
        next_word[WORD_W-1] = ~next_word[WORD_W-1];
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_valid_o <= 1'b0;
            out_word_o <= '0;
        end else begin
            out_valid_o <= dec_tick && !clear_i;
            if (dec_tick && !clear_i) begin
                out_word_o <= next_word;
            end
        end
    end
    a_filter_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clear_i |=> (dec_cnt == '0 && integ[ORDER] == '0 && !out_valid_o))
        else $error("filter state not cleared");
    a_word_rate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        out_valid_o |-> dec_cnt == '0)
        else $error("word out of decimation step");
endmodule
`default_nettype wire

// File: bench/adcm_reader.sv
// Reader model: drives the select pins and clocks a word out of the device.
// Assumes one system clock; sclk stays low between reads.
`timescale 1ns/1ns
`default_nettype none
module adcm_reader (
    // Clock
    input wire logic clk_i,
    // Device pins
    input wire logic pin_i,
    output logic sclk_o,
    output logic sel_high_o,
    output logic sel_low_o
);
    initial begin
        sclk_o = 1'b0;
        sel_high_o = 1'b0;
        sel_low_o = 1'b0;
    end

    // Callers change selects only after a finished read, except on purpose
    task automatic set_chan(input logic [1:0] code);
        @(posedge clk_i);
        {sel_high_o, sel_low_o} <= code;
    endtask

    // Six clocks per phase keeps clear of the device's two-flop sampling
    task automatic read_word(input int bits, output logic [23:0] word, output bit ok);
        int n;
        word = 24'h0;
        ok = 1'b0;
        n = 0;
        while (pin_i !== 1'b0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (pin_i !== 1'b0) return;
        ok = 1'b1;
        for (int i = 0; i < bits; i++) begin
            @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (6) @(posedge clk_i);
            word = {word[22:0], pin_i};
            sclk_o <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Testbench of the converter control block.
// Assumes adcm_reader as far side; bench drives the modulator bit itself.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int DIV = 6;
    // Smallest ratio whose accumulator still covers the full 24-bit word
    localparam int OSR = 32;
    localparam int SET = 5;
    logic clk_sys_i;
    logic nrst_i;
    logic mod_bit;
    logic sel_high;
    logic sel_low;
    logic sclk;
    logic mod_clk;
    adcm_pkg::adcm_chan_t mux_sel;
    logic pin;
    logic flag;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    adcm_top #(.MOD_DIV(DIV), .OSR(OSR), .SETTLE(SET)) dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .input_select_high_i(sel_high), .input_select_low_i(sel_low),
        .mod_bit_i(mod_bit), .mod_clk_o(mod_clk), .mux_sel_o(mux_sel),
        .sclk_i(sclk), .result_out_and_ready_pin_o(pin), .result_ready_flag_o(flag)
    );
    adcm_reader rd (
        .clk_i(clk_sys_i), .pin_i(pin), .sclk_o(sclk), .sel_high_o(sel_high), .sel_low_o(sel_low)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 4200 cycles the tests need
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic wait_ready(output int cyc);
        cyc = 0;
        while (pin !== 1'b0 && cyc < 2000) begin
            @(posedge clk_sys_i);
            cyc++;
        end
    endtask

    task automatic test_mux();
        for (int c = 0; c < 4; c++) begin
            rd.set_chan(c[1:0]);
            repeat (8) @(posedge clk_sys_i);
            check({22'h0, mux_sel}, 24'(c));
        end
        $display("test mux done");
    endtask

    // Full-scale input after a restart: timing of the first ready and its word
    task automatic test_settle();
        int cyc;
        logic [23:0] w;
        bit ok;
        @(posedge clk_sys_i);
        mod_bit <= 1'b1;
        rd.set_chan(2'h2);
        wait_ready(cyc);
        check({23'h0, cyc >= SET * OSR * DIV}, 24'h1);
        check({23'h0, cyc <= (SET + 2) * OSR * DIV}, 24'h1);
        check({23'h0, flag}, 24'h1);
        rd.read_word(24, w, ok);
        check(w, 24'h7fffff);
        check({23'h0, pin}, 24'h1);
        $display("test settle done");
    endtask

    // A ready pending from the old channel must not survive the change
    task automatic test_new_chan();
        logic [23:0] w;
        bit ok;
        repeat (100) @(posedge clk_sys_i);
        mod_bit <= 1'b0;
        rd.set_chan(2'h1);
        // Let the restart reach the pin before the reader looks for ready
        repeat (8) @(posedge clk_sys_i);
        check({23'h0, pin}, 24'h1);
        rd.read_word(24, w, ok);
        check({23'h0, ok}, 24'h1);
        check(w, 24'h800000);
        $display("test new channel done");
    endtask

    // Change in mid-read aborts readout; next word belongs to the new channel
    task automatic test_abort();
        logic [23:0] w;
        bit ok;
        @(posedge clk_sys_i);
        mod_bit <= 1'b1;
        rd.read_word(8, w, ok);
        rd.set_chan(2'h3);
        repeat (8) @(posedge clk_sys_i);
        check({22'h0, pin, flag}, 24'h2);
        check({22'h0, mux_sel}, 24'h3);
        rd.read_word(24, w, ok);
        check(w, 24'h7fffff);
        $display("test abort done");
    endtask

    task automatic test_mod_clk();
        int n;
        logic prev;
        n = 0;
        @(posedge mod_clk);
        @(posedge clk_sys_i);
        prev = mod_clk;
        @(posedge clk_sys_i);
        while (!(mod_clk === 1'b1 && prev === 1'b0) && n < 20) begin
            prev = mod_clk;
            @(posedge clk_sys_i);
            n++;
        end
        check(n[23:0], 24'(DIV - 1));
        $display("test modulator clock done");
    endtask

    initial begin
        nrst_i = 1'b0;
        mod_bit = 1'b0;
        repeat (3) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        check({23'h0, pin}, 24'h1);
        test_mux();
        test_settle();
        test_new_chan();
        test_abort();
        test_mod_clk();
        finish_test();
    end
endmodule
`default_nettype wire
